/* adctc_consts.svh */
// adctc_consts.svh: offsets, field positions, codes and reset values
// assumes inclusion by the adc trigger/compare block files only
`ifndef ADCTC_CONSTS_SVH
`define ADCTC_CONSTS_SVH
`define ADCTC_AW 8
`define ADCTC_OFF_TRG 8'h00
`define ADCTC_OFF_CMP 8'h04
`define ADCTC_OFF_LIM 8'h08
`define ADCTC_OFF_MODE 8'h0C
`define ADCTC_OFF_SWT 8'h10
`define ADCTC_SEL_W 5
`define ADCTC_SEL_STRIDE 8
`define ADCTC_SEL_MASK 32'h1F1F_1F1F
`define ADCTC_CODE_NONE 5'h00
`define ADCTC_CODE_GEDGE 5'h01
`define ADCTC_CODE_GLEVEL 5'h02
`define ADCTC_CODE_SCAN 5'h03
`define ADCTC_CODE_EXTERNAL_IRQ_0 5'h04
`define ADCTC_CODE_TIMER_1 5'h05
`define ADCTC_CODE_TIMER_3 5'h06
`define ADCTC_CODE_TIMER_5 5'h07
`define ADCTC_CODE_OC1 5'h08
`define ADCTC_CODE_OC3 5'h09
`define ADCTC_CODE_OC5 5'h0A
`define ADCTC_CODE_CMP1 5'h0B
`define ADCTC_CODE_CMP2 5'h0C
`define ADCTC_CODE_RSV 5'h0D
`define ADCTC_BIT_EN 7
`define ADCTC_BIT_IRQEN 6
`define ADCTC_BIT_FLAG 5
`define ADCTC_ID_LSB 8
`define ADCTC_DIFF_LSB 16
`define ADCTC_NORM_IDS 7'h20
`define ADCTC_CVD_MAX_ID 6'h2C
`define ADCTC_FRACTIONAL_FORMAT_SH 3
`define ADCTC_ZERO32 32'h0000_0000
`endif

/* adctc_dcmp.sv */
// adctc_dcmp.sv: digital comparator condition evaluation
// assumes result, limits and condition bits are stable in the sampled cycle
`timescale 1ns/1ps
`default_nettype none
`include "adctc_consts.svh"
module adctc_dcmp (
  input wire logic [4:0] cond,
  input wire logic [15:0] lo,
  input wire logic [15:0] hi,
  input wire logic [15:0] data,
  input wire logic [5:0] id,
  input wire logic capacitive_divider_mode,
  output logic hit
);
  logic id_ok;

  // normal mode watches inputs 0..31, cvd mode every class 2/3 input
  assign id_ok = capacitive_divider_mode ? (id <= `ADCTC_CVD_MAX_ID) : ({1'b0, id} < `ADCTC_NORM_IDS);

  always_comb
  begin
    hit = 1'b0;
    if (cond[4] && lo <= data && data <= hi)
      hit = 1'b1;
    if (cond[3] && data > hi)
      hit = 1'b1;
    if (cond[2] && data <= hi)
      hit = 1'b1;
    if (cond[1] && data >= lo)
      hit = 1'b1;
    if (cond[0] && data < lo)
      hit = 1'b1;
    hit = hit && id_ok;
  end
endmodule
`default_nettype wire

/* adctc_partner.sv */
// adctc_partner.sv: behavioural trigger sources and adc conversion core
// assumes the bench calls its tasks; every change lands just after a pclk rise
`timescale 1ns/1ps
`default_nettype none
module adctc_partner (
  input wire logic pclk,
  output var adctc_pkg::adctc_src_t src,
  output var adctc_pkg::adctc_res_t res
);
  initial
  begin
    src = '0;
    res = '0;
  end
  // scan line stands for a scan source that software has already set up
  task automatic pulse_src(input int b, input int hold);
    @(posedge pclk);
    src[b] <= 1'b1;
    repeat (hold) @(posedge pclk);
    src[b] <= 1'b0;
  endtask
  task automatic pulse_all();
    @(posedge pclk);
    src <= '1;
    repeat (2) @(posedge pclk);
    src <= '0;
  endtask
  // outside the strobe the fields show the inverse, not stale data
  task automatic send_res(input logic [5:0] id, input logic [15:0] d);
    @(posedge pclk);
    res <= {1'b1, id, d, 12'h010, 12'h020};
    @(posedge pclk);
    res <= {1'b0, ~id, ~d, 12'hFEF, 12'hFDF};
  endtask
endmodule
`default_nettype wire

/* adctc_pkg.sv */
// adctc_pkg.sv: types shared by the adc trigger/compare block
// assumes adctc_consts.svh is compiled alongside
package adctc_pkg;
  typedef struct packed {
    logic cmp2;
    logic cmp1;
    logic oc5;
    logic oc3;
    logic oc1;
    logic timer_5;
    logic timer_3;
    logic timer_1;
    logic external_irq_0;
    logic scan;
  } adctc_src_t;
  typedef struct packed {
    logic valid;
    logic [5:0] id;
    logic [15:0] data;
    logic [11:0] pos;
    logic [11:0] neg;
  } adctc_res_t;
  typedef enum logic [1:0] {
    ADCTC_IDLE = 2'b00,
    ADCTC_ACK = 2'b01
  } adctc_bus_st_t;
endpackage

/* adctc_top.sv */
// adctc_top.sv: adc trigger selection and digital comparator, apb slave
// assumes all inputs synchronous to pclk; ce low freezes all state
`timescale 1ns/1ps
`default_nettype none
`include "adctc_consts.svh"
// How it works
// - code 0 no trigger, 1 global edge software, 2 global level software.
// - codes 4..12 select external_irq_0, timers, output compares, analog comparators.
// - codes 13 to 31 are reserved and never trigger.
// - four 5-bit selectors at bits 28-24, 20-16, 12-8, 4-0.
// - unused trigger register bits ignore writes, read zero.
// - in cvd mode differential result loads upper half on comparator interrupt.
// - captured differential is signed, formatted by the fractional setting.
// - a true event records the input id in bits 13-8, read-only.
// - input n is encoded as binary n.
// - normal mode inputs 0..31 only; cvd mode all class 2/3 inputs.
// - enable bit 7 turns comparator on; clearing it zeroes the event flag.
// - with bit 6 set, a comparator interrupt follows each flag set.
// - flag bit 5 set by true compare, cleared on id read or disable.
// - output true only under enabled condition bits 4-0.
// - between condition: low limit <= result <= high limit, inclusive.
module adctc_top #(
  parameter int unsigned N_IN = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADCTC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adctc_pkg::adctc_src_t src,
  input wire adctc_pkg::adctc_res_t res,
  output logic [N_IN-1:0] trig_out,
  output logic cmp_event,
  output logic cmp_irq
);
  adctc_pkg::adctc_bus_st_t st_reg;
  logic [N_IN*`ADCTC_SEL_W-1:0] sel_reg;
  logic en_reg;
  logic irqen_reg;
  logic flag_reg;
  logic [4:0] cond_reg;
  logic [5:0] id_reg;
  logic [15:0] diff_reg;
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  logic cvd_reg;
  logic fractional_format_reg;
  logic glevel_reg;
  logic gedge_reg;
  logic [N_IN-1:0] trig_next;
  logic hit;
  logic take;
  logic done;
  logic wr;
  logic rd_cmp;
  logic set_evt;
  logic [31:0] rd_next;
  logic [15:0] diff_next;
  logic [12:0] diff13;

  function automatic logic mapped(input logic [`ADCTC_AW-1:0] a);
    mapped = a == `ADCTC_OFF_TRG || a == `ADCTC_OFF_CMP || a == `ADCTC_OFF_LIM ||
             a == `ADCTC_OFF_MODE || a == `ADCTC_OFF_SWT;
  endfunction

  function automatic logic [31:0] pack_sel(input logic [N_IN*`ADCTC_SEL_W-1:0] s);
    pack_sel = `ADCTC_ZERO32;
    for (int i = 0; i < N_IN; i++)
      pack_sel[i*`ADCTC_SEL_STRIDE +: `ADCTC_SEL_W] = s[i*`ADCTC_SEL_W +: `ADCTC_SEL_W];
  endfunction

  // apb: setup, first access cycle loads data, second completes
  assign take = ce && psel && penable && st_reg == adctc_pkg::ADCTC_IDLE;
  assign done = ce && psel && penable && st_reg == adctc_pkg::ADCTC_ACK;
  assign wr = done && pwrite && mapped(paddr);
  assign rd_cmp = done && !pwrite && paddr == `ADCTC_OFF_CMP;

  always_comb
  begin
    case (paddr)
      `ADCTC_OFF_TRG: rd_next = pack_sel(sel_reg);
      `ADCTC_OFF_CMP: rd_next = {diff_reg, 2'b00, id_reg, en_reg, irqen_reg,
                                 flag_reg, cond_reg};
      `ADCTC_OFF_LIM: rd_next = {hi_reg, lo_reg};
      `ADCTC_OFF_MODE: rd_next = {30'h0000_0000, fractional_format_reg, cvd_reg};
      `ADCTC_OFF_SWT: rd_next = {30'h0000_0000, glevel_reg, 1'b0};
      default: rd_next = `ADCTC_ZERO32;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= adctc_pkg::ADCTC_IDLE;
    else if (ce)
    begin
      case (st_reg)
        adctc_pkg::ADCTC_IDLE:
          if (psel && penable)
            st_reg <= adctc_pkg::ADCTC_ACK;
        adctc_pkg::ADCTC_ACK:
          st_reg <= adctc_pkg::ADCTC_IDLE;
        default:
          st_reg <= adctc_pkg::ADCTC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `ADCTC_ZERO32;
    end
    else if (ce)
    begin
      pready <= take;
      pslverr <= take && !mapped(paddr);
      if (take && !pwrite)
        prdata <= rd_next;
    end
  end

  // trigger selectors
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_reg <= '0;
    else if (wr && paddr == `ADCTC_OFF_TRG)
    begin
      for (int i = 0; i < N_IN; i++)
        sel_reg[i*`ADCTC_SEL_W +: `ADCTC_SEL_W] <=
          pwdata[i*`ADCTC_SEL_STRIDE +: `ADCTC_SEL_W];
    end
  end

  // global software triggers: edge is a one-cycle pulse per write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gedge_reg <= 1'b0;
      glevel_reg <= 1'b0;
    end
    else if (ce)
    begin
      gedge_reg <= wr && paddr == `ADCTC_OFF_SWT && pwdata[0];
      if (wr && paddr == `ADCTC_OFF_SWT)
        glevel_reg <= pwdata[1];
    end
  end

  adctc_trig_sel #(
    .N(N_IN)
  ) u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .sel(sel_reg),
    .src(src),
    .gedge(gedge_reg),
    .glevel(glevel_reg),
    .trig(trig_next)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_out <= '0;
    else if (ce)
      trig_out <= trig_next;
  end

  // comparator configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_reg <= 1'b0;
      irqen_reg <= 1'b0;
      cond_reg <= 5'h00;
      lo_reg <= 16'h0000;
      hi_reg <= 16'h0000;
      cvd_reg <= 1'b0;
      fractional_format_reg <= 1'b0;
    end
    else if (wr)
    begin
      case (paddr)
        `ADCTC_OFF_CMP:
        begin
          en_reg <= pwdata[`ADCTC_BIT_EN];
          irqen_reg <= pwdata[`ADCTC_BIT_IRQEN];
          cond_reg <= pwdata[4:0];
        end
        `ADCTC_OFF_LIM:
        begin
          lo_reg <= pwdata[15:0];
          hi_reg <= pwdata[31:16];
        end
        `ADCTC_OFF_MODE:
        begin
          cvd_reg <= pwdata[0];
          fractional_format_reg <= pwdata[1];
        end
        default:
        begin
        end
      endcase
    end
  end

  adctc_dcmp u_dcmp (
    .cond(cond_reg),
    .lo(lo_reg),
    .hi(hi_reg),
    .data(res.data),
    .id(res.id),
    .capacitive_divider_mode(cvd_reg),
    .hit(hit)
  );

  assign set_evt = ce && en_reg && res.valid && hit;

  // event flag: set wins over read-clear, disable forces zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_reg <= 1'b0;
    else if (wr && paddr == `ADCTC_OFF_CMP && !pwdata[`ADCTC_BIT_EN])
      flag_reg <= 1'b0;
    else if (set_evt)
      flag_reg <= 1'b1;
    else if (rd_cmp)
      flag_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      id_reg <= 6'h00;
    else if (set_evt)
      id_reg <= res.id;
  end

  // signed differential, left-justified when fractional
  assign diff13 = {1'b0, res.pos} - {1'b0, res.neg};
  assign diff_next = fractional_format_reg ? {diff13, 3'b000} : {{3{diff13[12]}}, diff13};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      diff_reg <= 16'h0000;
    else if (set_evt && irqen_reg && cvd_reg)
      diff_reg <= diff_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_irq <= 1'b0;
    else if (ce)
      cmp_irq <= set_evt && irqen_reg && !flag_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_event <= 1'b0;
    else if (ce)
      cmp_event <= set_evt || (flag_reg && !rd_cmp && en_reg);
  end

  a_rsv_read_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    take && !pwrite && paddr == `ADCTC_OFF_TRG |=> (prdata & ~`ADCTC_SEL_MASK) == 0)
    else $error("trigger register reserved bits read nonzero");

  a_code_rsv_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && sel_reg[`ADCTC_SEL_W-1:0] >= `ADCTC_CODE_RSV |=> !trig_out[0])
    else $error("reserved trigger code fired");

  a_code_none_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && sel_reg[`ADCTC_SEL_W-1:0] == `ADCTC_CODE_NONE |=> !trig_out[0])
    else $error("no-trigger code fired");

  a_level_trig_on: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && glevel_reg && sel_reg[`ADCTC_SEL_W-1:0] == `ADCTC_CODE_GLEVEL |=> trig_out[0])
    else $error("level software trigger missed");

  a_flag_off_disabled: assert property (
    @(posedge pclk) disable iff (!presetn)
    !en_reg |-> !flag_reg)
    else $error("event flag set while comparator off");

  a_irq_follows_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    set_evt && irqen_reg && !flag_reg |=> cmp_irq && flag_reg)
    else $error("comparator interrupt missing");

  a_id_recorded: assert property (
    @(posedge pclk) disable iff (!presetn)
    set_evt |=> flag_reg && id_reg == $past(res.id))
    else $error("input id not recorded");

  a_read_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_cmp && !set_evt |=> !flag_reg)
    else $error("id read did not clear flag");

  a_cvd_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    set_evt && irqen_reg && cvd_reg |=> diff_reg == $past(diff_next))
    else $error("differential not captured");

  a_between_hit: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && en_reg && res.valid && cond_reg[4] && !cvd_reg && res.id < 6'h20 &&
    lo_reg <= res.data && res.data <= hi_reg |=> flag_reg)
    else $error("between event missed");
endmodule
`default_nettype wire

/* adctc_top_tb.sv */
// adctc_top_tb.sv: self-checking bench for the adc trigger/compare block
// assumes adctc_partner drives trigger sources and conversion results
`timescale 1ns/1ps
`default_nettype none
module adctc_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  adctc_pkg::adctc_src_t src;
  adctc_pkg::adctc_res_t res;
  logic [3:0] trig_out;
  logic [3:0] trig_acc = 4'h0;
  logic cmp_event;
  logic cmp_irq;
  int irq_n = 0;
  int errors = 0;
  int check_count = 0;
  logic [31:0] q;
  logic e;
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    trig_acc <= trig_acc | trig_out;
    if (cmp_irq === 1'b1)
      irq_n <= irq_n + 1;
  end
  adctc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src(src), .res(res), .trig_out(trig_out), .cmp_event(cmp_event),
    .cmp_irq(cmp_irq));
  adctc_partner p (.pclk(pclk), .src(src), .res(res));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
      errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic clr_acc();
    @(negedge pclk);
    trig_acc = 4'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(q, 32'h0);
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    apb(1'b0, 8'h00, 32'h0);
    check(q, 32'h1F1F_1F1F);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    apb(1'b0, 8'h04, 32'h0);
    check(q, 32'h0000_00DF);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
  endtask
  task automatic t_hw_codes();
    for (int c = 3; c < 32; c++)
    begin
      apb(1'b1, 8'h00, 32'(c) << (8 * (c % 4)));
      clr_acc();
      if (c <= 12)
        p.pulse_src(c - 3, 1 + c % 3);
      else
        p.pulse_all();
      settle(4);
      check({28'h0, trig_acc}, (c <= 12) ? 32'(1 << (c % 4)) : 32'h0);
    end
  endtask
  task automatic t_sw();
    apb(1'b1, 8'h00, 32'h0101_0101);
    clr_acc();
    apb(1'b1, 8'h10, 32'h1);
    settle(3);
    check({28'h0, trig_acc}, 32'hF);
    apb(1'b1, 8'h00, 32'h0202_0202);
    apb(1'b1, 8'h10, 32'h2);
    settle(3);
    check({28'h0, trig_out}, 32'hF);
    apb(1'b1, 8'h00, 32'h0);
    // the level trigger is still registered for one cycle after the selector write
    settle(2);
    clr_acc();
    apb(1'b1, 8'h10, 32'h3);
    settle(3);
    check({28'h0, trig_acc}, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
  endtask
  task automatic ev(input logic [7:0] ctl, input logic [5:0] id, input logic [15:0] d,
                    input int exp);
    int n0;
    apb(1'b1, 8'h04, {24'h0, ctl});
    apb(1'b0, 8'h04, 32'h0);
    n0 = irq_n;
    p.send_res(id, d);
    settle(3);
    check(32'(irq_n - n0), 32'(exp));
    apb(1'b0, 8'h04, 32'h0);
  endtask
  task automatic t_cmp();
    apb(1'b1, 8'h08, 32'h0200_0100);
    ev(8'hD0, 6'd5, 16'h0100, 1);
    check(q, 32'h0000_05F0);
    apb(1'b0, 8'h04, 32'h0);
    check({31'h0, q[5]}, 32'h0);
    ev(8'hD0, 6'd7, 16'h0200, 1);
    ev(8'hD0, 6'd7, 16'h0201, 0);
    ev(8'hD0, 6'd7, 16'h00FF, 0);
    ev(8'hC8, 6'd3, 16'h0201, 1);
    ev(8'hC4, 6'd3, 16'h0200, 1);
    ev(8'hC2, 6'd3, 16'h0100, 1);
    ev(8'hC1, 6'd3, 16'h00FF, 1);
    ev(8'hC1, 6'd3, 16'h0100, 0);
    ev(8'hC0, 6'd3, 16'h0150, 0);
    ev(8'hD0, 6'd32, 16'h0150, 0);
    ev(8'h50, 6'd6, 16'h0150, 0);
    ev(8'h90, 6'd6, 16'h0150, 0);
    check({31'h0, q[5]}, 32'h1);
    p.send_res(6'd6, 16'h0150);
    settle(3);
    check({31'h0, cmp_event}, 32'h1);
    apb(1'b1, 8'h04, 32'h0000_0010);
    apb(1'b0, 8'h04, 32'h0);
    check({31'h0, q[5]}, 32'h0);
  endtask
  task automatic t_cvd();
    apb(1'b1, 8'h0C, 32'h1);
    ev(8'hD0, 6'd44, 16'h0150, 1);
    check(q, 32'hFFF0_2CF0);
    ev(8'hD0, 6'd45, 16'h0150, 0);
    apb(1'b1, 8'h0C, 32'h3);
    ev(8'hD0, 6'd40, 16'h0150, 1);
    check({16'h0, q[31:16]}, 32'h0000_FF80);
  endtask
  // with ce low a source edge and a hitting result must leave no trace
  task automatic t_ce();
    apb(1'b1, 8'h00, 32'h0505_0505);
    apb(1'b1, 8'h04, 32'h0000_00D0);
    apb(1'b0, 8'h04, 32'h0);
    clr_acc();
    @(posedge pclk);
    ce <= 1'b0;
    p.pulse_src(2, 1);
    p.send_res(6'd1, 16'h0150);
    @(posedge pclk);
    ce <= 1'b1;
    settle(3);
    check({28'h0, trig_acc}, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check({31'h0, q[5]}, 32'h0);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_hw_codes();
    t_sw();
    t_cmp();
    t_cvd();
    t_ce();
    stop_test();
  end
  initial
  begin
    #500us;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire

/* adctc_trig_sel.sv */
// adctc_trig_sel.sv: per-input trigger source selection
// assumes hardware sources are synchronous to pclk; output is combinational
`timescale 1ns/1ps
`default_nettype none
`include "adctc_consts.svh"
module adctc_trig_sel #(
  parameter int unsigned N = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [N*`ADCTC_SEL_W-1:0] sel,
  input wire adctc_pkg::adctc_src_t src,
  input wire logic gedge,
  input wire logic glevel,
  output logic [N-1:0] trig
);
  adctc_pkg::adctc_src_t prev_reg;
  adctc_pkg::adctc_src_t rise;

  // hardware sources trigger on their rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_reg <= '0;
    else if (ce)
      prev_reg <= src;
  end

  assign rise = src & ~prev_reg;

  function automatic logic pick(input logic [4:0] c, input adctc_pkg::adctc_src_t r,
                                input logic e, input logic l);
    case (c)
      `ADCTC_CODE_GEDGE: pick = e;
      `ADCTC_CODE_GLEVEL: pick = l;
      `ADCTC_CODE_SCAN: pick = r.scan;
      `ADCTC_CODE_EXTERNAL_IRQ_0: pick = r.external_irq_0;
      `ADCTC_CODE_TIMER_1: pick = r.timer_1;
      `ADCTC_CODE_TIMER_3: pick = r.timer_3;
      `ADCTC_CODE_TIMER_5: pick = r.timer_5;
      `ADCTC_CODE_OC1: pick = r.oc1;
      `ADCTC_CODE_OC3: pick = r.oc3;
      `ADCTC_CODE_OC5: pick = r.oc5;
      `ADCTC_CODE_CMP1: pick = r.cmp1;
      `ADCTC_CODE_CMP2: pick = r.cmp2;
      default: pick = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    for (int i = 0; i < N; i++)
      trig[i] = pick(sel[i*`ADCTC_SEL_W +: `ADCTC_SEL_W], rise, gedge, glevel);
  end
endmodule
`default_nettype wire
